// ==== core/prs_panel_rail_sequencer.sv ====
// sequencing, registers and serial slave for two boost rails
// ============================================================
// Overview of operation
// - Over-temperature stops all switching while the trip input is high
// - Protection bit two enables over-temperature
// - Positive rail target from six-bit field
// - Positive rail code resets to 0x22
// - Positive soft-start 5 to 40 ms
// - Positive soft-start end means rail ready
// - Positive delay 0 to 75 ms, 4 bits
// - Positive delay starts at trim load done
// - Four slew settings, normal after reset
// - Peak current ends positive low-side on-time
// - Gate-high soft-start 5 to 20 ms
// - Gate-high soft-start end means ready
// - Gate-high delay 0 to 75 ms
// - Gate-high delay starts at positive soft-start
// - Zero gate delay waits for pre-charge
// - Peak current ends gate-high low-side on-time
// - Output gating switch held until release
// - Two-bit frequency codes, reset 600 kHz
// - Pre-charge finish gates positive soft-start
`timescale 1ns/1ps
`include "prs_regs.svh"
module prs_panel_rail_sequencer
  import prs_pkg::*;
#(
  parameter int TICK_CYCLES = `PRS_MS_NS / `PRS_CLK_NS
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic input_undervoltage_lockout,
  input wire logic trim_load_done,
  input wire logic precharge_ok,
  input wire logic otp_trip,
  input wire logic pos_cycle_start,
  input wire logic pos_pwm_on,
  input wire logic pos_peak_limit,
  input wire logic gate_cycle_start,
  input wire logic gate_pwm_on,
  input wire logic gate_peak_limit,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [5:0] pos_ref_code,
  output logic [5:0] gate_ref_level,
  output logic pos_ready,
  output logic gate_ready,
  output logic output_gating_switch_on,
  output logic pos_lowside_on,
  output logic gate_lowside_on,
  output logic [1:0] pos_freq_code,
  output logic [1:0] gate_freq_code,
  output logic [1:0] pos_slew_code
);
  // ============================================================
  // registers
  logic [7:0] pos_vcode, pos_delay, pos_soft, gate_delay, gate_soft;
  logic [7:0] prot_en;
  logic wr_pulse;
  logic [7:0] wr_addr, wr_data;
  logic otp_shutdown;

  function automatic logic [5:0] ramp(input logic [5:0] target,
    input logic [7:0] elapsed, input logic [7:0] total);
    logic [13:0] prod;
    prod = 14'(target) * 14'(elapsed);
    if (total == 8'h00 || elapsed >= total) begin
      ramp = target;
    end else begin
      ramp = 6'(prod / 14'(total));
    end
  endfunction

  function automatic logic [7:0] ms_of(input logic [7:0] steps);
    ms_of = 8'(steps * `PRS_STEP_MS);
  endfunction

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pos_vcode <= `PRS_RST_POS_VCODE;
      pos_delay <= `PRS_RST_POS_DELAY;
      pos_soft <= `PRS_RST_POS_SOFT;
      gate_delay <= `PRS_RST_GATE_DELAY;
      gate_soft <= `PRS_RST_GATE_SOFT;
      prot_en <= `PRS_RST_PROT_EN;
      pos_freq_code <= 2'h0;
      gate_freq_code <= 2'h0;
      pos_slew_code <= 2'h2;
    end else if (wr_pulse) begin
      unique case (wr_addr)
        `PRS_OFS_POS_VCODE: pos_vcode <= wr_data;
        `PRS_OFS_POS_DELAY: pos_delay <= wr_data;
        `PRS_OFS_POS_SOFT: pos_soft <= wr_data;
        `PRS_OFS_GATE_DELAY: gate_delay <= wr_data;
        `PRS_OFS_GATE_SOFT: gate_soft <= wr_data;
        `PRS_OFS_PROT_EN: prot_en <= wr_data;
        `PRS_OFS_SWITCH_CFG: begin
          pos_freq_code <= wr_data[`PRS_POS_FREQ_LSB +: 2];
          gate_freq_code <= wr_data[`PRS_GATE_FREQ_LSB +: 2];
          pos_slew_code <= wr_data[`PRS_SLEW_LSB +: 2];
        end
        default: ;
      endcase
    end
  end

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    unique case (a)
      `PRS_OFS_POS_VCODE: read_reg = pos_vcode;
      `PRS_OFS_POS_DELAY: read_reg = pos_delay;
      `PRS_OFS_POS_SOFT: read_reg = pos_soft;
      `PRS_OFS_GATE_DELAY: read_reg = gate_delay;
      `PRS_OFS_GATE_SOFT: read_reg = gate_soft;
      `PRS_OFS_PROT_EN: read_reg = prot_en;
      `PRS_OFS_SWITCH_CFG: read_reg = {2'h0, pos_slew_code,
        gate_freq_code, pos_freq_code};
      `PRS_OFS_STATUS: read_reg = {5'h00, otp_shutdown, gate_ready,
        pos_ready};
      default: read_reg = 8'h00;
    endcase
  endfunction

  // ============================================================
  // serial slave, scl and sda sampled on ref_clk
  prs_i2c_state_type i2c_state;
  logic scl_q, sda_q, rw, ack_phase, mack;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, ptr, tx;
  logic [7:0] rd_now, rd_next;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign start_cond = scl && scl_q && sda_q && !sda_in;
  assign stop_cond = scl && scl_q && !sda_q && sda_in;

  // read data for the current and the following pointer
  always_comb begin
    rd_now = read_reg(ptr);
    rd_next = read_reg(ptr + 8'h01);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      i2c_state <= I_IDLE;
      rw <= 1'b0;
      ack_phase <= 1'b0;
      mack <= 1'b0;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      tx <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_pulse <= 1'b0;
      if (start_cond) begin
        i2c_state <= I_ADDR;
        bit_cnt <= 4'h0;
        ack_phase <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        i2c_state <= I_IDLE;
        sda_oe <= 1'b0;
      end else if (i2c_state != I_IDLE && scl_rise) begin
        if (ack_phase) begin
          mack <= !sda_in;
        end else begin
          shreg <= {shreg[6:0], sda_in};
          bit_cnt <= bit_cnt + 4'h1;
        end
      end else if (i2c_state != I_IDLE && scl_fall) begin
        if (!ack_phase && bit_cnt == 4'h8) begin
          ack_phase <= 1'b1;
          bit_cnt <= 4'h0;
          sda_oe <= 1'b0;
          unique case (i2c_state)
            I_ADDR: begin
              if (shreg[7:1] == `PRS_I2C_ADDR) begin
                rw <= shreg[0];
                sda_oe <= 1'b1;
              end else begin
                i2c_state <= I_IDLE;
              end
            end
            I_REG: begin
              ptr <= shreg;
              sda_oe <= 1'b1;
            end
            I_DATA: begin
              if (!rw) begin
                wr_pulse <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shreg;
                ptr <= ptr + 8'h01;
                sda_oe <= 1'b1;
              end
            end
            default: i2c_state <= I_IDLE;
          endcase
        end else if (ack_phase) begin
          ack_phase <= 1'b0;
          sda_oe <= 1'b0;
          if (i2c_state == I_ADDR) begin
            i2c_state <= rw ? I_DATA : I_REG;
          end else if (i2c_state == I_REG) begin
            i2c_state <= I_DATA;
          end
          if ((i2c_state == I_ADDR && rw) || (rw && mack)) begin
            tx <= rd_now;
            sda_oe <= !rd_now[7];
            if (i2c_state != I_ADDR) begin
              tx <= rd_next;
              sda_oe <= !rd_next[7];
              ptr <= ptr + 8'h01;
            end
          end else if (rw && i2c_state == I_DATA) begin
            i2c_state <= I_IDLE;
          end
        end else if (rw && i2c_state == I_DATA) begin
          sda_oe <= !tx[3'(4'h7 - bit_cnt)];
        end
      end
    end
  end

  // ============================================================
  // millisecond tick and timers
  logic [15:0] tick_cnt;
  logic ms_tick, seq_clear;
  assign seq_clear = !enable || input_undervoltage_lockout;

  always_ff @(posedge ref_clk) begin
    if (!rstn || seq_clear) begin
      tick_cnt <= 16'h0000;
      ms_tick <= 1'b0;
    end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
      tick_cnt <= 16'h0000;
      ms_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      ms_tick <= 1'b0;
    end
  end

  prs_tmr_if pos_t ();
  prs_tmr_if gate_t ();
  prs_ms_timer u_pos_timer (.ref_clk(ref_clk), .rstn(rstn), .t(pos_t));
  prs_ms_timer u_gate_timer (.ref_clk(ref_clk), .rstn(rstn), .t(gate_t));

  // ============================================================
  // positive rail sequence
  prs_pos_state_type pos_state;
  logic pos_delay_go, pos_soft_go;
  assign pos_delay_go = pos_state == P_IDLE && trim_load_done;
  assign pos_soft_go = pos_state == P_PRE && precharge_ok;
  assign pos_t.clear = seq_clear;
  assign pos_t.tick = ms_tick;
  assign pos_t.start = pos_delay_go || pos_soft_go;
  assign pos_t.length = pos_delay_go ?
    ms_of(8'(pos_delay[`PRS_DELAY_MSB:0])) :
    ms_of(8'(pos_soft[`PRS_POS_SOFT_MSB:0]) + 8'h01);

  always_ff @(posedge ref_clk) begin
    if (!rstn || seq_clear) begin
      pos_state <= P_IDLE;
    end else begin
      unique case (pos_state)
        P_IDLE: if (pos_delay_go) pos_state <= P_DELAY;
        P_DELAY: if (pos_t.done) pos_state <= P_PRE;
        P_PRE: if (pos_soft_go) pos_state <= P_SOFT;
        P_SOFT: if (pos_t.done) pos_state <= P_RUN;
        P_RUN: pos_state <= P_RUN;
      endcase
    end
  end

  // ============================================================
  // gate-high rail sequence
  prs_gate_state_type gate_state;
  logic gate_zero, gate_delay_go, gate_soft_go;
  assign gate_delay_go = gate_state == G_IDLE && pos_soft_go;
  assign gate_soft_go = gate_state == G_DELAY && gate_t.done &&
    (!gate_zero || pos_state == P_SOFT || pos_state == P_RUN);
  assign gate_t.clear = seq_clear;
  assign gate_t.tick = ms_tick;
  assign gate_t.start = gate_delay_go || gate_soft_go;
  assign gate_t.length = gate_delay_go ?
    ms_of(8'(gate_delay[`PRS_DELAY_MSB:0])) :
    ms_of(8'(gate_soft[`PRS_GATE_SOFT_MSB:0]) + 8'h01);

  always_ff @(posedge ref_clk) begin
    if (!rstn || seq_clear) begin
      gate_state <= G_IDLE;
      gate_zero <= 1'b0;
    end else begin
      unique case (gate_state)
        G_IDLE: begin
          if (gate_delay_go) begin
            gate_state <= G_DELAY;
            gate_zero <= gate_delay[`PRS_DELAY_MSB:0] == 4'h0;
          end
        end
        G_DELAY: if (gate_soft_go) gate_state <= G_SOFT;
        G_SOFT: if (gate_t.done) gate_state <= G_RUN;
        G_RUN: gate_state <= G_RUN;
      endcase
    end
  end

  // ============================================================
  // references, ready flags and switch gating
  logic pos_hit, gate_hit, pos_sw_ok, gate_sw_ok;
  assign pos_sw_ok = (pos_state == P_SOFT || pos_state == P_RUN) &&
    !otp_shutdown;
  assign gate_sw_ok = (gate_state == G_SOFT || gate_state == G_RUN) &&
    !otp_shutdown;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      otp_shutdown <= 1'b0;
    end else begin
      otp_shutdown <= otp_trip && prot_en[`PRS_OTP_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pos_ref_code <= 6'h00;
      gate_ref_level <= 6'h00;
      pos_ready <= 1'b0;
      gate_ready <= 1'b0;
      output_gating_switch_on <= 1'b0;
    end else begin
      pos_ref_code <= pos_state == P_SOFT ?
        ramp(pos_vcode[`PRS_VCODE_MSB:0], pos_t.elapsed,
          pos_t.length) :
        (pos_state == P_RUN ? pos_vcode[`PRS_VCODE_MSB:0] : 6'h00);
      gate_ref_level <= gate_state == G_SOFT ?
        ramp(`PRS_RAMP_FULL, gate_t.elapsed, gate_t.length) :
        (gate_state == G_RUN ? `PRS_RAMP_FULL : 6'h00);
      pos_ready <= pos_state == P_RUN;
      gate_ready <= gate_state == G_RUN;
      output_gating_switch_on <= gate_state == G_SOFT ||
        gate_state == G_RUN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pos_hit <= 1'b0;
      gate_hit <= 1'b0;
      pos_lowside_on <= 1'b0;
      gate_lowside_on <= 1'b0;
    end else begin
      pos_hit <= (pos_peak_limit && pos_pwm_on) ||
        (pos_hit && !pos_cycle_start);
      gate_hit <= (gate_peak_limit && gate_pwm_on) ||
        (gate_hit && !gate_cycle_start);
      pos_lowside_on <= pos_sw_ok && pos_pwm_on && !pos_peak_limit &&
        !pos_hit;
      gate_lowside_on <= gate_sw_ok && gate_pwm_on && !gate_peak_limit &&
        !gate_hit;
    end
  end

  // ============================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_otp_stops_all: assert property (
    otp_trip && prot_en[`PRS_OTP_EN_BIT] |=> ##1
    !pos_lowside_on && !gate_lowside_on)
    else $error("switching continued in over-temperature");
  a_otp_masked: assert property (
    !prot_en[`PRS_OTP_EN_BIT] |=> !otp_shutdown)
    else $error("over-temperature acted while disabled");
  a_vcode_reset: assert property (
    $rose(rstn) |-> pos_vcode == `PRS_RST_POS_VCODE)
    else $error("voltage code reset value wrong");
  a_pos_ready_soft: assert property (
    $rose(pos_ready) |-> $past(pos_state, 2) == P_SOFT)
    else $error("ready without soft-start end");
  a_delay_start: assert property (
    pos_state == P_IDLE && trim_load_done && !seq_clear |=>
    pos_state == P_DELAY && pos_t.elapsed == 8'h00)
    else $error("delay did not start on trim load");
  a_pos_limit: assert property (
    pos_peak_limit && pos_pwm_on && !pos_cycle_start |=>
    !pos_lowside_on ##1 !pos_lowside_on)
    else $error("positive switch on after peak limit");
  a_gate_limit: assert property (
    gate_peak_limit |=> !gate_lowside_on)
    else $error("gate-high switch on after peak limit");
  a_gate_waits_pre: assert property (
    gate_state == G_SOFT |-> pos_state inside {P_SOFT, P_RUN})
    else $error("gate-high started before pre-charge");
  a_gate_release: assert property (
    output_gating_switch_on |-> $past(gate_state) inside {G_SOFT, G_RUN})
    else $error("gating switch released early");
  a_lockout_clear: assert property (
    seq_clear |=> pos_state == P_IDLE && gate_state == G_IDLE ##1
    !pos_ready && !gate_ready)
    else $error("lockout did not clear sequence");

  c_pos_run: cover property (pos_state == P_SOFT ##1 pos_state == P_RUN);
  c_gate_run: cover property ($rose(gate_ready));
  c_otp: cover property ($rose(otp_shutdown));
  c_reg_write: cover property (wr_pulse);
endmodule // prs_panel_rail_sequencer

// ==== core/prs_regs.svh ====
// register offsets, reset values, field positions and timing constants
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH

// serial target address
`define PRS_I2C_ADDR 7'h6B

// register offsets
`define PRS_OFS_POS_VCODE 8'h00
`define PRS_OFS_POS_DELAY 8'h07
`define PRS_OFS_POS_SOFT 8'h08
`define PRS_OFS_GATE_DELAY 8'h0B
`define PRS_OFS_GATE_SOFT 8'h0C
`define PRS_OFS_SWITCH_CFG 8'h10
`define PRS_OFS_PROT_EN 8'h14
`define PRS_OFS_STATUS 8'h15

// reset values
`define PRS_RST_POS_VCODE 8'h22
`define PRS_RST_POS_DELAY 8'h01
`define PRS_RST_POS_SOFT 8'h01
`define PRS_RST_GATE_DELAY 8'h05
`define PRS_RST_GATE_SOFT 8'h00
`define PRS_RST_SWITCH_CFG 8'h20
`define PRS_RST_PROT_EN 8'h07

// field positions
`define PRS_VCODE_MSB 5
`define PRS_POS_SOFT_MSB 2
`define PRS_DELAY_MSB 3
`define PRS_GATE_SOFT_MSB 1
`define PRS_OTP_EN_BIT 2
`define PRS_POS_FREQ_LSB 0
`define PRS_GATE_FREQ_LSB 2
`define PRS_SLEW_LSB 4
`define PRS_ST_POS_READY 0
`define PRS_ST_GATE_READY 1
`define PRS_ST_OTP 2

// timing
`define PRS_CLK_NS 40
`define PRS_MS_NS 1000000
`define PRS_STEP_MS 8'd5
`define PRS_RAMP_FULL 6'h3F

`endif

// ==== core/prs_pkg.sv ====
// types shared by the rail sequencer modules
package prs_pkg;

  typedef enum logic [4:0] {
    P_IDLE  = 5'b00001,
    P_DELAY = 5'b00010,
    P_PRE   = 5'b00100,
    P_SOFT  = 5'b01000,
    P_RUN   = 5'b10000
  } prs_pos_state_type;

  typedef enum logic [3:0] {
    G_IDLE  = 4'b0001,
    G_DELAY = 4'b0010,
    G_SOFT  = 4'b0100,
    G_RUN   = 4'b1000
  } prs_gate_state_type;

  typedef enum logic [3:0] {
    I_IDLE  = 4'b0001,
    I_ADDR  = 4'b0010,
    I_REG   = 4'b0100,
    I_DATA  = 4'b1000
  } prs_i2c_state_type;

endpackage

// ==== core/prs_tmr_if.sv ====
// millisecond timer control bundle
`timescale 1ns/1ps
interface prs_tmr_if;
  logic start;
  logic clear;
  logic tick;
  logic [7:0] length;
  logic [7:0] elapsed;
  logic done;
  modport ctrl (output start, output clear, output tick, output length,
    input elapsed, input done);
  modport timer (input start, input clear, input tick, input length,
    output elapsed, output done);
endinterface

// ==== core/prs_ms_timer.sv ====
// millisecond timer counting a common tick up to a latched length
`timescale 1ns/1ps
module prs_ms_timer
  import prs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  prs_tmr_if.timer t
);
  logic [7:0] len;
  logic run;

  // length is latched at start so later writes wait for the next start
  always_ff @(posedge ref_clk) begin
    if (!rstn || t.clear) begin
      len <= 8'h00;
      run <= 1'b0;
      t.elapsed <= 8'h00;
      t.done <= 1'b0;
    end else if (t.start) begin
      len <= t.length;
      run <= 1'b1;
      t.elapsed <= 8'h00;
      t.done <= (t.length == 8'h00);
    end else if (run && t.tick && !t.done) begin
      t.elapsed <= t.elapsed + 8'h01;
      t.done <= ((t.elapsed + 8'h01) == len);
    end
  end

  a_timer_expiry: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(t.done) && !$past(t.start) |-> t.elapsed == len)
    else $error("timer expired at wrong count");
endmodule // prs_ms_timer

// ==== verif/prs_host_model.sv ====
// serial host model driving the sequencer register port
`timescale 1ns/1ps
`include "prs_regs.svh"
module prs_host_model (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  localparam int HALF = 4;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // ============================================================
  // bus conditions
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic start_cond();
    cyc(1);
    sda_pull <= 1'b0;
    cyc(2);
    scl <= 1'b1;
    cyc(HALF);
    sda_pull <= 1'b1;
    cyc(HALF);
    scl <= 1'b0;
    cyc(2);
  endtask
  task automatic stop_cond();
    sda_pull <= 1'b1;
    cyc(2);
    scl <= 1'b1;
    cyc(HALF);
    sda_pull <= 1'b0;
    cyc(HALF);
  endtask
  // data changes only while clock is low
  task automatic xfer_bit(input logic b, output logic s);
    sda_pull <= ~b;
    cyc(2);
    scl <= 1'b1;
    cyc(HALF);
    s = sda_line;
    scl <= 1'b0;
    cyc(2);
  endtask
  // ============================================================
  // byte and register transfers
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
    output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], s);
      q[i] = s;
    end
    xfer_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic write_reg(input logic [6:0] adr, input logic [7:0] ofs,
    input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    byte_io({adr, 1'b0}, q, a0);
    byte_io(ofs, q, a1);
    byte_io(d, q, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    start_cond();
    byte_io({`PRS_I2C_ADDR, 1'b0}, d, a);
    byte_io(ofs, d, a);
    start_cond();
    byte_io({`PRS_I2C_ADDR, 1'b1}, d, a);
    byte_io(8'hFF, d, a);
    stop_cond();
  endtask
endmodule // prs_host_model

// ==== verif/tb_top.sv ====
// self-checking bench for the panel rail sequencer
`timescale 1ns/1ps
`include "prs_regs.svh"
module tb_top;
  import prs_pkg::*;
  localparam int TICK = 5;
  localparam int MS5 = 5 * TICK;
  localparam int SL = 2 * TICK + 6;
  localparam int LIMIT = 40000;
  localparam logic [7:0] OFS [7] = '{8'h00, 8'h07, 8'h08, 8'h0B, 8'h0C,
    8'h10, 8'h14};
  localparam logic [7:0] RST [7] = '{8'h22, 8'h01, 8'h01, 8'h05, 8'h00,
    8'h20, 8'h07};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic enable = 1'b1;
  logic trim = 1'b0;
  logic pre = 1'b0;
  logic otp = 1'b0;
  logic pcs = 1'b0;
  logic ppwm = 1'b0;
  logic ppk = 1'b0;
  logic gcs = 1'b0;
  logic gpwm = 1'b0;
  logic gpk = 1'b0;
  logic scl, sda_pull, sda_out, sda_oe, ok, mono;
  logic pos_ready, gate_ready, gsw, pls, gls;
  logic [5:0] pos_ref_code, gate_ref_level, last;
  logic [1:0] pfq, gfq, slew;
  logic [7:0] cfg;
  wire sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
  int bad_count = 0;
  int n_checks = 0;
  int cnt = 0;
  int vc, pd, ps, gd, gs, t_p, t_s, t_g;
  integer seed = 32'hE09F2A82;
  logic [7:0] mdl [int];

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cnt++;
    if (cnt == LIMIT) begin
      bad_count++;
      end_of_test();
    end
  end

  prs_panel_rail_sequencer #(.TICK_CYCLES(TICK)) prs_panel_rail_sequencer_i (
    .ref_clk(ref_clk), .rstn(rstn), .enable(enable),
    .input_undervoltage_lockout(1'b0), .trim_load_done(trim),
    .precharge_ok(pre), .otp_trip(otp), .pos_cycle_start(pcs),
    .pos_pwm_on(ppwm), .pos_peak_limit(ppk), .gate_cycle_start(gcs),
    .gate_pwm_on(gpwm), .gate_peak_limit(gpk), .scl(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .pos_ref_code(pos_ref_code), .gate_ref_level(gate_ref_level),
    .pos_ready(pos_ready), .gate_ready(gate_ready),
    .output_gating_switch_on(gsw), .pos_lowside_on(pls),
    .gate_lowside_on(gls), .pos_freq_code(pfq), .gate_freq_code(gfq),
    .pos_slew_code(slew));
  prs_host_model prs_host_model_i (.ref_clk(ref_clk), .sda_line(sda_line),
    .scl(scl), .sda_pull(sda_pull));

  // ============================================================
  // checking and bus helpers
  task automatic check(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    prs_host_model_i.write_reg(`PRS_I2C_ADDR, a, d, k);
    check("write ack", {7'h00, k}, 8'h01);
    mdl[a] = d;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] d;
    prs_host_model_i.read_reg(a, d);
    check($sformatf("reg %h", a), d, mdl.exists(a) ? mdl[a] : 8'h00);
  endtask
  task automatic pulse_cs();
    pcs <= 1'b1;
    gcs <= 1'b1;
    @(posedge ref_clk);
    pcs <= 1'b0;
    gcs <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic ls(input logic e);
    #1;
    check("pos lowside", {7'h00, pls}, {7'h00, e});
    check("gate lowside", {7'h00, gls}, {7'h00, e});
    @(posedge ref_clk);
  endtask
  function automatic logic [7:0] near(input int t, input int e);
    return {7'h00, t >= e - SL && t <= e + SL};
  endfunction

  // ============================================================
  // main sequence
  initial begin
    for (int i = 0; i < 7; i++) mdl[OFS[i]] = RST[i];
    mdl[8'h15] = 8'h00;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("slew", {6'h00, slew}, 8'h02);
    check("freq", {4'h0, gfq, pfq}, 8'h00);
    for (int i = 0; i < 7; i++) rd_chk(OFS[i]);
    rd_chk(8'h15);
    prs_host_model_i.write_reg(7'h6A, 8'h00, 8'h15, ok);
    check("foreign ack", {7'h00, ok}, 8'h00);
    prs_host_model_i.write_reg(`PRS_I2C_ADDR, 8'h30, 8'hA5, ok);
    prs_host_model_i.write_reg(`PRS_I2C_ADDR, 8'h15, 8'hFF, ok);
    rd_chk(8'h30);
    rd_chk(8'h15);
    vc = $unsigned($random(seed)) % 47;
    pd = $unsigned($random(seed)) % 4;
    ps = $unsigned($random(seed)) % 8;
    gd = 1 + $unsigned($random(seed)) % 4;
    gs = $unsigned($random(seed)) % 4;
    cfg = $random(seed);
    wr(8'h00, vc[7:0]);
    wr(8'h07, pd[7:0]);
    wr(8'h08, ps[7:0]);
    wr(8'h0B, gd[7:0]);
    wr(8'h0C, gs[7:0]);
    wr(8'h10, cfg);
    mdl[8'h10] = {2'b00, cfg[5:0]};
    for (int i = 0; i < 7; i++) rd_chk(OFS[i]);
    check("cfg pins", {2'b00, slew, gfq, pfq}, {2'b00, cfg[5:0]});
    // ============================================================
    // power-up sequence
    trim <= 1'b1;
    repeat ((pd + 3) * MS5) @(posedge ref_clk);
    #1;
    check("early ready", {7'h00, pos_ready}, 8'h00);
    check("early switch", {7'h00, gsw}, 8'h00);
    @(posedge ref_clk);
    pre <= 1'b1;
    t_p = -1;
    t_s = -1;
    t_g = -1;
    last = 6'h00;
    mono = 1'b1;
    for (int c = 0; c < 900 && (t_g < 0 || t_p < 0); c++) begin
      @(posedge ref_clk);
      #1;
      if (pos_ref_code < last) mono = 1'b0;
      last = pos_ref_code;
      if (pos_ready && t_p < 0) t_p = c;
      if (gsw && t_s < 0) t_s = c;
      if (gate_ready && t_g < 0) t_g = c;
    end
    check("ramp order", {7'h00, mono}, 8'h01);
    check("pos soft", near(t_p, (ps + 1) * MS5 + 2), 8'h01);
    check("gate start", near(t_s, gd * MS5 + 2), 8'h01);
    check("gate soft", near(t_g, (gd + gs + 1) * MS5 + 4), 8'h01);
    check("pos code", {2'b00, pos_ref_code}, vc[7:0]);
    check("gate ramp", {2'b00, gate_ref_level}, 8'h3F);
    @(posedge ref_clk);
    mdl[8'h15] = 8'h03;
    rd_chk(8'h15);
    // ============================================================
    // switch gating
    ppwm <= 1'b1;
    gpwm <= 1'b1;
    pulse_cs();
    ls(1'b1);
    ppk <= 1'b1;
    gpk <= 1'b1;
    @(posedge ref_clk);
    ppk <= 1'b0;
    gpk <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ls(1'b0);
    pulse_cs();
    ls(1'b1);
    otp <= 1'b1;
    pulse_cs();
    ls(1'b0);
    otp <= 1'b0;
    pulse_cs();
    ls(1'b1);
    wr(8'h14, 8'h03);
    otp <= 1'b1;
    pulse_cs();
    ls(1'b1);
    otp <= 1'b0;
    enable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    check("off state", {5'h00, pos_ready, gate_ready, gsw}, 8'h00);
    end_of_test();
  end
endmodule // tb_top
